// [rtl/prd_filter.sv]
// Spike filter for one two-wire input line.
// Assumes input already passed through a two-flop synchroniser.
module prd_filter (
  input  wire logic clk_i,  // System clock
  input  wire logic rst_i,  // Sync reset
  input  wire logic d_i,    // Synchronised input
  output logic      q_o     // Filtered level
);
  import prd_pkg::*;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic       next_q;

  always_comb begin
    next_cnt = 2'h0;
    next_q   = q_o;
    if (d_i != q_o) begin
      next_cnt = cnt + 2'h1;
      if (cnt + 2'h1 >= SPIKE_CYC_W) begin
        next_q   = d_i;
        next_cnt = 2'h0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 2'h0;
      q_o <= 1'b1;
    end else begin
      cnt <= next_cnt;
      q_o <= next_q;
    end
  end
endmodule : prd_filter

// [rtl/prd_pins.sv]
// Pin control: debug port strap, reset pull defaults, two-wire open drain, slow RC clock out.
// Assumes por_i comes from the power-on detector; pin levels are sampled through two flops.
// Function
// - Debug port enabled when test clock pin low at reset release.
// - Debug port enabled: pull-ups on clock, mode, data-in; data-out driven, no pull.
// - Test clock pull-up stays on throughout reset.
// - Debug port disabled: its four pins revert to general I/O or peripherals.
// - After reset two-wire function is selected on two-wire capable lines.
// - Two-wire lines drive only low unless the trace port owns them, and filter input spikes.
// - Each line has its own programmable pull-up enable.
// - Reset default: input, pull-up off, except port A line 0.
// - Port A line 20 defaults to function F, enabled.
// - Slow RC clock driven on line 20 from power-up, even during power-on reset.
// - Clock out disabled by other function, general I/O, or keep bit zero.
// - Once disabled, clock output stays off until the next power-on reset.
// - Secondary crystal output alone does not disable clock output.
// - Analog input blocked while the line drives high.
// - Last function in priority list wins on a shared pin.
// - Enabled debug port overrides I/O controller configuration.
module prd_pins #(
  parameter int unsigned N = prd_pkg::NUM_LINES  // Number of I/O lines
) (
  input  wire logic           clk_i,         // System clock
  input  wire logic           rst_i,         // Sync reset, active high
  input  wire logic           por_i,         // Power-on reset, active high
  input  wire logic           ext_rst_n_i,   // External reset pin, active low
  input  wire logic [N-1:0]   pin_in_i,      // Pad input levels
  input  wire logic [N-1:0]   cfg_periph_i,  // 1: peripheral, 0: general I/O
  input  wire logic [N*3-1:0] cfg_func_i,    // Peripheral function per line
  input  wire logic [N-1:0]   cfg_oe_i,      // General I/O output enable
  input  wire logic [N-1:0]   cfg_out_i,     // General I/O output value
  input  wire logic [N-1:0]   cfg_pull_i,    // Pull-up enable per line
  input  wire logic           cfg_load_i,    // Pulse: take the cfg_* values
  input  wire logic [N-1:0]   per_oe_i,      // Peripheral output enables
  input  wire logic [N-1:0]   per_out_i,     // Peripheral output values
  input  wire logic [N-1:0]   twi_line_i,    // Line is two-wire capable
  input  wire logic           trace_en_i,    // Trace port owns its lines
  input  wire logic [N-1:0]   trace_mask_i,  // Trace line map
  input  wire logic [N-1:0]   trace_out_i,   // Trace output values
  input  wire logic           dbg_oe_i,      // Debug data-out enable (line 0)
  input  wire logic           dbg_out_i,     // Debug data-out value
  input  wire logic           tdo_i,         // Test port data-out value
  input  wire logic           keep_i,        // Clock-out keep bit
  input  wire logic           xout2_en_i,    // Secondary crystal output enabled
  input  wire logic           rc_clk_i,      // Slow RC oscillator clock
  input  wire logic [N-1:0]   adc_req_i,     // Analog input request
  output logic [N-1:0]        pin_out_o,     // Pad output value
  output logic [N-1:0]        pin_oe_o,      // Pad output enable
  output logic [N-1:0]        pin_pull_o,    // Pad pull-up enable
  output logic [N-1:0]        pin_sync_o,    // Synchronised pin level to peripherals; filtered on two-wire peripheral lines
  output logic [N-1:0]        adc_en_o,      // Analog switch enable
  output logic                test_en_o,     // Test port enabled
  output logic                tck_o,         // Test clock to test port
  output logic                tms_o,         // Mode select to test port
  output logic                tdi_o,         // Data-in to test port
  output logic                rc_out_en_o    // Slow RC clock output enabled
);
  import prd_pkg::*;

  logic [N-1:0]   periph, oe, out, pull;
  logic [N*3-1:0] func;
  logic [N-1:0]   next_periph, next_oe, next_out, next_pull;
  logic [N*3-1:0] next_func;
  logic [N-1:0]   s1, s2, filt;
  logic           rs1, rs2, rst_pin_q, test_en, next_test_en;
  logic           rc_dead, next_rc_dead;

  function automatic logic [2:0] func_of(input logic [N*3-1:0] f, input int unsigned i);
    func_of = f[i*3 +: 3];
  endfunction : func_of

  // Config bank; reset defaults
  always_comb begin
    next_periph = periph;
    next_func   = func;
    next_oe     = oe;
    next_out    = out;
    next_pull   = pull;
    if (cfg_load_i) begin
      next_periph = cfg_periph_i;
      next_func   = cfg_func_i;
      next_oe     = cfg_oe_i;
      next_out    = cfg_out_i;
      next_pull   = cfg_pull_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periph <= TWI_LINES_RST[N-1:0] | PMUX_EN_RST[N-1:0];
      func   <= (N*3)'(FUNC_F) << (LINE_PORT_A_LINE_20 * 3);
      oe     <= '0;
      out    <= '0;
      pull   <= PULLUP_RST[N-1:0];
    end else begin
      periph <= next_periph;
      func   <= next_func;
      oe     <= next_oe;
      out    <= next_out;
      pull   <= next_pull;
    end
  end

  // Synchronisers and external reset edge
  always_ff @(posedge clk_i) begin
    s1  <= pin_in_i;
    s2  <= s1;
    rs1 <= ext_rst_n_i;
    rs2 <= rs1;
  end

  always_comb begin
    next_test_en = test_en;
    if (rs2 && !rst_pin_q)
      next_test_en = !s2[LINE_PORT_A_LINE_0];
  end

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      // Idle pin level: power-on alone is no release, only a real low-high edge straps
      rst_pin_q <= 1'b1;
      test_en   <= 1'b0;
    end else begin
      rst_pin_q <= rs2;
      test_en   <= next_test_en;
    end
  end

  // Sticky clock-out disable, cleared by power-on only
  always_comb begin
    next_rc_dead = rc_dead;
    if (!rst_i && (!periph[LINE_PORT_A_LINE_20] || func_of(func, LINE_PORT_A_LINE_20) != FUNC_F || !keep_i))
      next_rc_dead = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (por_i)
      rc_dead <= 1'b0;
    else
      rc_dead <= next_rc_dead;
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_filt
      prd_filter u_filt (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (s2[g]),
        .q_o   (filt[g])
      );
    end
  endgenerate

  // Output mux; later owners override earlier ones
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pin_out_o[i]  = periph[i] ? per_out_i[i] : out[i];
      pin_oe_o[i]   = periph[i] ? per_oe_i[i] : oe[i];
      pin_pull_o[i] = pull[i];
      pin_sync_o[i] = s2[i];
      if (periph[i] && twi_line_i[i]) begin
        pin_oe_o[i]   = per_oe_i[i] && !per_out_i[i];
        pin_out_o[i]  = 1'b0;
        pin_sync_o[i] = filt[i];
      end
      if (trace_en_i && trace_mask_i[i]) begin
        pin_out_o[i] = trace_out_i[i];
        pin_oe_o[i]  = 1'b1;
      end
    end
    if (dbg_oe_i) begin
      pin_out_o[LINE_PORT_A_LINE_0] = dbg_out_i;
      pin_oe_o[LINE_PORT_A_LINE_0]  = 1'b1;
    end
    if (test_en) begin
      pin_oe_o[LINE_PORT_A_LINE_0]   = 1'b0;
      pin_oe_o[LINE_PA01]   = 1'b0;
      pin_oe_o[LINE_PA03]   = 1'b0;
      pin_oe_o[LINE_PA02]   = 1'b1;
      pin_out_o[LINE_PA02]  = tdo_i;
      pin_pull_o[LINE_PORT_A_LINE_0] = 1'b1;
      pin_pull_o[LINE_PA01] = 1'b1;
      pin_pull_o[LINE_PA03] = 1'b1;
      pin_pull_o[LINE_PA02] = 1'b0;
    end
    if (!rc_dead) begin
      pin_out_o[LINE_PORT_A_LINE_20] = rc_clk_i;
      pin_oe_o[LINE_PORT_A_LINE_20]  = 1'b1;
    end
    if (por_i || rst_i || !rs2)
      pin_pull_o[LINE_PORT_A_LINE_0] = 1'b1;
    for (int i = 0; i < N; i++)
      adc_en_o[i] = adc_req_i[i] && !(pin_oe_o[i] && pin_out_o[i]);
  end

  assign test_en_o   = test_en;
  assign tck_o       = test_en & s2[LINE_PORT_A_LINE_0];
  assign tms_o       = test_en & s2[LINE_PA01];
  assign tdi_o       = test_en & s2[LINE_PA03];
  assign rc_out_en_o = !rc_dead;

  // Checks
  a_strap_capture: assert property (@(posedge clk_i) disable iff (por_i)
    (rs2 && !rst_pin_q) |=> (test_en == !$past(s2[LINE_PORT_A_LINE_0]))) else $error("strap not captured");
  a_test_pulls: assert property (@(posedge clk_i) disable iff (por_i)
    test_en |-> (pin_pull_o[LINE_PA01] && pin_pull_o[LINE_PA03] && !pin_pull_o[LINE_PA02]
                 && pin_oe_o[LINE_PA02])) else $error("test pins wrong");
  a_tck_pull_rst: assert property (@(posedge clk_i) rst_i |-> pin_pull_o[LINE_PORT_A_LINE_0])
    else $error("test clock pull-up off in reset");
  a_twi_open_drain: assert property (@(posedge clk_i) disable iff (rst_i)
    (periph[5] && twi_line_i[5] && !(trace_en_i && trace_mask_i[5])) |-> !(pin_oe_o[5] && pin_out_o[5]))
    else $error("two-wire line drove high");
  a_rst_defaults: assert property (@(posedge clk_i) $fell(rst_i) |->
    (oe == '0 && pull == PULLUP_RST[N-1:0] && func_of(func, LINE_PORT_A_LINE_20) == FUNC_F)) else $error("bad reset defaults");
  a_rc_kill: assert property (@(posedge clk_i) disable iff (por_i || rst_i)
    !keep_i |=> rc_dead) else $error("keep bit zero ignored");
  a_rc_sticky: assert property (@(posedge clk_i) disable iff (por_i)
    rc_dead |=> rc_dead [*3]) else $error("clock out re-enabled");
  a_rc_drive: assert property (@(posedge clk_i)
    !rc_dead |-> (pin_oe_o[LINE_PORT_A_LINE_20] && pin_out_o[LINE_PORT_A_LINE_20] == rc_clk_i)) else $error("clock not driven");
  a_adc_block: assert property (@(posedge clk_i)
    (pin_oe_o[LINE_PORT_A_LINE_20] && pin_out_o[LINE_PORT_A_LINE_20]) |-> !adc_en_o[LINE_PORT_A_LINE_20]) else $error("analog not blocked");
  c_test_on:  cover property (@(posedge clk_i) $rose(test_en));
  c_rc_off:   cover property (@(posedge clk_i) $rose(rc_dead));
  c_xout_rc:  cover property (@(posedge clk_i) xout2_en_i && !rc_dead);
endmodule : prd_pins

// [rtl/prd_pkg.sv]
// Package for the pin reset-default and clock-out block.
// Assumes a single 50 MHz system clock and synchronous active-high reset.
package prd_pkg;
  localparam int unsigned NUM_LINES        = 64;   // Port A lines 0..31, port B lines 32..63
  localparam int unsigned FUNC_W           = 3;    // Peripheral function select A..H
  localparam int unsigned LINE_PORT_A_LINE_0        = 0;
  localparam int unsigned LINE_PA01        = 1;
  localparam int unsigned LINE_PA02        = 2;
  localparam int unsigned LINE_PA03        = 3;
  localparam int unsigned LINE_PORT_A_LINE_20        = 20;
  localparam logic [2:0]  FUNC_F           = 3'h5;
  localparam logic [63:0] TWI_LINES_RST    = 64'h0000_0030_0022_00a0; // PA05/07/17/21, PB04/05
  localparam logic [63:0] PULLUP_RST       = 64'h0000_0000_0000_0001; // Only port A line 0
  localparam logic [63:0] PMUX_EN_RST      = 64'h0000_0000_0010_0000; // Line 20 peripheral
  localparam int unsigned SPIKE_NS         = 50;
  localparam int unsigned CLK_NS           = 20;
  localparam int unsigned SPIKE_CYC        = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0]  SPIKE_CYC_W      = 2'(SPIKE_CYC);
  typedef enum logic [1:0] {PRD_OWN_MUX, PRD_OWN_TRACE, PRD_OWN_DBG, PRD_OWN_TEST} prd_owner_t;
endpackage : prd_pkg

// [testbench/prd_board.sv]
// Board model: pad pull-ups, debug probe strap on line 0.
// Assumes the pad outputs of prd_pins on one clock.
module prd_board (
  input  wire logic        clk_i,      // System clock
  input  wire logic [63:0] out_i,      // Pad output value
  input  wire logic [63:0] oe_i,       // Pad output enable
  input  wire logic [63:0] pull_i,     // Pad pull-up enable
  input  wire logic        probe_lo_i, // Probe holds test clock low
  output logic [63:0]      lvl_o       // Resolved pad level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] flt = '0;
  // Floating pads toggle so a stale level never reads as valid
  always @(posedge clk_i) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      lvl_o[i] = oe_i[i] ? out_i[i] : (pull_i[i] ? 1'b1 : flt[i]);
    end
    if (probe_lo_i && !oe_i[0]) begin
      lvl_o[0] = 1'b0;
    end
  end
endmodule : prd_board

// [testbench/tb_prd_pins.sv]
// Self-checking bench for prd_pins.
// Assumes prd_board as the pads; one 50 MHz clock.
module tb_prd_pins;
  import prd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, por_i, ext_rst_n, load_p, tdo, keep, xout2, tr_en, probe_lo, dbg_oe, dbg_out;
  logic rc_clk = 1'b0;
  logic [63:0] lvl, periph, oe, out, pull, per_oe, per_out, tr_mask, tr_out, adc_req;
  logic [63:0] p_out, p_oe, p_pull, p_sync, adc_en;
  logic [191:0] func;
  logic test_en, tck, tms, tdi, rc_en;
  int error_cnt, n_tests;

  prd_board brd (.clk_i(clk_i), .out_i(p_out), .oe_i(p_oe), .pull_i(p_pull), .probe_lo_i(probe_lo), .lvl_o(lvl));
  prd_pins dut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .ext_rst_n_i(ext_rst_n), .pin_in_i(lvl),
    .cfg_periph_i(periph), .cfg_func_i(func), .cfg_oe_i(oe), .cfg_out_i(out), .cfg_pull_i(pull),
    .cfg_load_i(load_p), .per_oe_i(per_oe), .per_out_i(per_out), .twi_line_i(TWI_LINES_RST),
    .trace_en_i(tr_en), .trace_mask_i(tr_mask), .trace_out_i(tr_out), .dbg_oe_i(dbg_oe), .dbg_out_i(dbg_out),
    .tdo_i(tdo), .keep_i(keep), .xout2_en_i(xout2), .rc_clk_i(rc_clk), .adc_req_i(adc_req),
    .pin_out_o(p_out), .pin_oe_o(p_oe), .pin_pull_o(p_pull), .pin_sync_o(p_sync), .adc_en_o(adc_en),
    .test_en_o(test_en), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .rc_out_en_o(rc_en));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // Power-on plus reset; p holds the probe low through release
  task automatic rstp(input logic p);
    ext_rst_n <= 1'b0;
    probe_lo <= p;
    por_i <= 1'b1;
    rst_i <= 1'b1;
    keep <= 1'b1;
    periph <= TWI_LINES_RST | PMUX_EN_RST;
    pull <= PULLUP_RST;
    oe <= '0;
    out <= '0;
    func <= 192'(FUNC_F) << 60;
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    chk(64'(p_pull[0]), 64'h1);
    chk(64'(rc_en), 64'h1);
    @(posedge clk_i);
    por_i <= 1'b0;
    rst_i <= 1'b0;
    ext_rst_n <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask : rstp

  task automatic load;
    load_p <= 1'b1;
    @(posedge clk_i);
    load_p <= 1'b0;
    @(negedge clk_i);
  endtask : load

  initial begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) rc_clk <= ~rc_clk;

  initial begin
    #100_000;
    error_cnt++;
    conclude;
  end

  initial begin
    {rst_i, por_i, ext_rst_n, load_p, tdo, keep, xout2, tr_en, probe_lo, dbg_oe, dbg_out} = '0;
    {periph, oe, out, pull, per_oe, per_out, tr_mask, tr_out, adc_req, func} = '0;
    error_cnt = 0;
    n_tests = 0;
    rstp(1'b0);
    @(negedge clk_i);
    chk(64'(test_en), 64'h0);
    chk(p_pull, PULLUP_RST);
    chk(p_oe & ~PMUX_EN_RST, 64'h0);
    chk(64'(rc_en), 64'h1);
    @(posedge clk_i);
    per_oe <= TWI_LINES_RST;
    per_out <= TWI_LINES_RST;
    @(negedge clk_i);
    chk(p_oe & TWI_LINES_RST, 64'h0);
    @(posedge clk_i);
    per_out <= '0;
    repeat (8) @(negedge clk_i);
    chk(p_oe & TWI_LINES_RST, TWI_LINES_RST);
    chk(p_out & TWI_LINES_RST, 64'h0);
    chk(64'(p_sync[5]), 64'h0);
    @(posedge clk_i);
    per_oe <= '0;
    // Undriven pad now toggles every cycle: filtered level must hold
    repeat (8) @(negedge clk_i);
    chk(64'(p_sync[5]), 64'h0);
    @(posedge clk_i);
    pull <= 64'h0000_0c00_0f00_0a11;
    oe <= 64'h101;
    out <= 64'h100;
    adc_req <= '1;
    load;
    chk(p_pull, 64'h0000_0c00_0f00_0a11);
    chk(64'(p_oe[0]), 64'h1);
    chk(64'(adc_en[8]), 64'h0);
    @(posedge clk_i);
    out <= '0;
    load;
    chk(64'(adc_en[8]), 64'h1);
    @(posedge clk_i);
    tr_en <= 1'b1;
    tr_mask <= 64'h1;
    dbg_oe <= 1'b1;
    dbg_out <= 1'b1;
    @(negedge clk_i);
    chk(64'({p_oe[0], p_out[0]}), 64'h3);
    @(posedge clk_i);
    dbg_oe <= 1'b0;
    @(negedge clk_i);
    chk(64'({p_oe[0], p_out[0]}), 64'h2);
    @(posedge clk_i);
    tr_en <= 1'b0;
    tr_mask <= '0;
    @(posedge clk_i);
    xout2 <= 1'b1;
    repeat (3) @(negedge clk_i);
    chk(64'(rc_en), 64'h1);
    @(posedge clk_i);
    keep <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk(64'(rc_en), 64'h0);
    @(posedge clk_i);
    keep <= 1'b1;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk(64'(rc_en), 64'h0);
    for (int k = 0; k < 3; k++) begin
      rstp(1'b0);
      keep <= (k != 2);
      periph <= (k == 1) ? TWI_LINES_RST : (TWI_LINES_RST | PMUX_EN_RST);
      func <= 192'((k == 0) ? 3'h4 : FUNC_F) << 60;
      load;
      @(negedge clk_i);
      chk(64'(rc_en), 64'h0);
    end
    rstp(1'b1);
    tdo <= 1'b1;
    tr_en <= 1'b1;
    tr_mask <= 64'hf;
    @(negedge clk_i);
    chk(64'(test_en), 64'h1);
    chk(64'(p_pull[3:0]), 64'hb);
    chk(64'(p_oe[2]), 64'h1);
    chk(64'(p_out[2]), 64'h1);
    repeat (2) @(negedge clk_i);
    chk(64'({tck, tms, tdi}), 64'h3);
    @(posedge clk_i);
    probe_lo <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk(64'(tck), 64'h1);
    conclude;
  end
endmodule : tb_prd_pins
